// *** mic_cfg.svh ***
// offsets, field positions, reset values and vector constants of the interrupt controller
// assumes inclusion by bare name from the controller and its package users
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH
// register offsets on the plain register port
`define MIC_ADDR_SENS      8'h00
`define MIC_ADDR_PINSEL    8'h01
`define MIC_ADDR_STATUS    8'h02
`define MIC_ADDR_LASTSRC   8'h03
// reset values
`define MIC_SENS_RESET     8'h00
`define MIC_PINSEL_RESET   8'h0c
// vectors
`define MIC_VEC_RESET      16'hfffe
`define MIC_VEC_TRAP       16'hfffc
`define MIC_VEC_SRC0       16'hfffa
// source numbers
`define MIC_NUM_SRC        14
`define MIC_SRC_AWU        4'h0
`define MIC_SRC_EXT0       4'h1
`define MIC_SRC_UNUSED_A   4'h6
`define MIC_SRC_AT_OVF     4'h9
`define MIC_SRC_TB_ONE     4'hb
`define MIC_SRC_SPI        4'hc
`define MIC_SRC_UNUSED_B   4'hd
// status and last-source register fields
`define MIC_STAT_MASK_BIT  4
`define MIC_LAST_TRAP_BIT  7
// pin code that keeps external line 2 off the halt wake list (port b line 4)
`define MIC_LINE2_NOHALT   2'h1
`endif

// *** mic_intc.sv ***
// interrupt controller: ext line capture, priority, vector and context sequencing, wake logic
// assumes pins and core events are synchronous to clk_i; peripherals hold their own flag latches
//
// Functional notes
// - maskable service only while mask bit clear
// - mask bit set after any reset
// - finish instruction, save context, mask, vector; the code raises the mask the cycle after the vector load
// - return restores context and clears mask
// - lowest pending source number wins
// - trap ignores mask; trap and reset vectors
// - source vectors descend from fffa; 6,13 unused
// - any source wakes from wait
// - halt wake: ext lines, spi; awu only wakeup_from_halt_mode
// - active-halt wake: timer overflow, time base one
// - edge event latched, cleared on service entry
// - low enabled nand input blocks request
// - peripheral request needs enable and clear mask
// - software clears flag, pending request lost
// - sensitivity register: four 2-bit fields, reset zero
// - sensitivity codes: fall+low, rise, fall, both
// - sensitivity writes only while mask set
// - sensitivity change clears line's pending request
// - line 3 pin from port b 0,1,2
// - line 2 pin port b 3..6; b4 no halt wake
// - line 1 pin port a 4..7, reset 7
// - line 0 pin port a 0..3
`timescale 1ns/1ps
`include "mic_cfg.svh"

module mic_intc
(
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	// register port
	input  wire logic [7:0]             reg_addr_i,
	input  wire logic [7:0]             reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [7:0]             reg_rdata_o,
	// pins
	input  wire logic [7:0]             port_a_i,
	input  wire logic [6:0]             port_b_i,
	input  wire logic [3:0]             nand_block_n_i,
	// peripheral flags and enables, per source number
	input  wire logic [13:0]            periph_flag_i,
	input  wire logic [13:0]            periph_en_i,
	// core side
	input  wire mic_pkg::mic_core_evt_t core_evt_i,
	input  wire mic_pkg::mic_lp_t       lp_mode_i,
	output mic_pkg::mic_core_cmd_t      core_cmd_o,
	output logic                        mask_o,
	output logic                        wake_o,
	output logic                        irq_pending_o
);
	// registers and state
	logic [7:0]           sens_q;
	logic [7:0]           pinsel_q;
	logic                 mask_q;
	logic [3:0]           ext_pend_q;
	logic [6:0]           ext_pin_q;
	mic_pkg::mic_state_t  state_q;
	mic_pkg::mic_core_cmd_t cmd_q;
	logic [3:0]           last_src_q;
	logic                 last_trap_q;
	logic                 wake_q;
	logic [7:0]           rdata_q;
	// combinational helpers
	logic [3:0]           ext_sel_pin;
	logic [3:0]           ext_rise;
	logic [3:0]           ext_fall;
	logic [3:0]           ext_event;
	logic [3:0]           ext_req;
	logic [3:0]           sens_change;
	logic                 sens_wr_ok;
	logic [13:0]          src_req;
	logic [13:0]          src_en_req;
	logic                 any_req;
	logic [3:0]           win_src;
	logic                 take_trap;
	logic                 take_irq;
	logic [3:0]           ext_ack;
	logic [13:0]          halt_wake_set;
	logic [13:0]          ahalt_wake_set;
	logic                 wake_d;
	logic [7:0]           rdata_d;
	// sensitivity writes are honoured only while the mask bit is set
	assign sens_wr_ok = reg_wr_i && (reg_addr_i == `MIC_ADDR_SENS) && mask_q;
	// per line: pin routing, edge detect, latch, request
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_line
			logic [1:0] psel;
			logic [1:0] sens;
			assign psel = pinsel_q[2*gi+1:2*gi];
			assign sens = sens_q[2*gi+1:2*gi];
			// pin mux per line
			if (gi == 0)
			begin : g_mux0
				assign ext_sel_pin[gi] = port_a_i[psel];
			end
			else if (gi == 1)
			begin : g_mux1
				assign ext_sel_pin[gi] = port_a_i[{1'b1, psel}];
			end
			else if (gi == 2)
			begin : g_mux2
				// codes 0..3 give port b lines 3..6
				assign ext_sel_pin[gi] = port_b_i[3'(psel) + 3'h3];
			end
			else
			begin : g_mux3
				// code 3 is undefined and falls back to port b line 0
				assign ext_sel_pin[gi] = (psel == 2'h3) ? port_b_i[0] : port_b_i[psel];
			end
			// edges against the previous pin sample
			assign ext_rise[gi] = ext_sel_pin[gi] & ~ext_pin_q[gi];
			assign ext_fall[gi] = ~ext_sel_pin[gi] & ext_pin_q[gi];
			// trigger decode by sensitivity code
			always_comb
			begin
				case (mic_pkg::mic_sens_t'(sens))
					mic_pkg::SENS_FALL_LOW: ext_event[gi] = ext_fall[gi];
					mic_pkg::SENS_RISE:     ext_event[gi] = ext_rise[gi];
					mic_pkg::SENS_FALL:     ext_event[gi] = ext_fall[gi];
					mic_pkg::SENS_BOTH:     ext_event[gi] = ext_rise[gi] | ext_fall[gi];
					default:                ext_event[gi] = 1'b0;
				endcase
			end
			// a write that changes this line's field drops its pending request
			assign sens_change[gi] = sens_wr_ok && (reg_wdata_i[2*gi+1:2*gi] != sens);
			// request: latched edge, or low level in code 00, blocked by a low nand input
			assign ext_req[gi] = (ext_pend_q[gi] |
				((sens == 2'h0) & ~ext_sel_pin[gi])) & nand_block_n_i[gi];
		end
	endgenerate

	// previous pin samples for edge detection; index 4..6 unused, kept one
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ext_pin_q <= 7'h7f;
		end
		else
		begin
			ext_pin_q <= {3'h7, ext_sel_pin};
		end
	end

	// edge latches: an event in the clearing cycle survives the clear
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ext_pend_q <= 4'h0;
		end
		else
		begin
			ext_pend_q <= (ext_pend_q & ~ext_ack & ~sens_change) | ext_event;
		end
	end

	// source vector: external lines replace the peripheral slots 1..4
	always_comb
	begin
		src_req = periph_flag_i & periph_en_i;
		src_req[4:1] = ext_req;
		src_req[`MIC_SRC_UNUSED_A] = 1'b0;
		src_req[`MIC_SRC_UNUSED_B] = 1'b0;
	end
	// requests visible to the core only while unmasked
	assign src_en_req = mask_q ? 14'h0000 : src_req;
	assign any_req = |src_en_req;
	// lowest index among pending sources
	always_comb
	begin
		win_src = 4'h0;
		for (int i = `MIC_NUM_SRC - 1; i >= 0; i--)
		begin
			if (src_en_req[i])
			begin
				win_src = 4'(i);
			end
		end
	end
	// acceptance at the end of an instruction; trap does not look at the mask
	assign take_trap = (state_q == mic_pkg::ST_IDLE) && core_evt_i.instr_end &&
		core_evt_i.trap;
	assign take_irq = (state_q == mic_pkg::ST_IDLE) && core_evt_i.instr_end &&
		!core_evt_i.trap && !core_evt_i.interrupt_return_instr && any_req;
	// entering a line's service routine acknowledges its edge latch
	always_comb
	begin
		ext_ack = 4'h0;
		if (take_irq && (win_src >= `MIC_SRC_EXT0) && (win_src <= 4'h4))
		begin
			ext_ack[2'(win_src - `MIC_SRC_EXT0)] = 1'b1;
		end
	end

	// context sequencer
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_q <= mic_pkg::ST_IDLE;
		end
		else
		begin
			case (state_q)
				mic_pkg::ST_IDLE:
				begin
					if (take_trap || take_irq)
					begin
						state_q <= mic_pkg::ST_SAVE;
					end
					else if (core_evt_i.instr_end && core_evt_i.interrupt_return_instr)
					begin
						state_q <= mic_pkg::ST_RESTORE;
					end
				end
				mic_pkg::ST_SAVE:    state_q <= mic_pkg::ST_FETCH;
				mic_pkg::ST_FETCH:   state_q <= mic_pkg::ST_IDLE;
				mic_pkg::ST_RESTORE: state_q <= mic_pkg::ST_IDLE;
				default:             state_q <= mic_pkg::ST_IDLE;
			endcase
		end
	end

	// commands to the core, one pulse per step, vector held until the next service
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			cmd_q <= '{save_ctx: 1'b0, load_vec: 1'b0, restore_ctx: 1'b0,
				vector: `MIC_VEC_RESET};
		end
		else
		begin
			cmd_q.save_ctx    <= (state_q == mic_pkg::ST_IDLE) && (take_trap || take_irq);
			cmd_q.load_vec    <= (state_q == mic_pkg::ST_SAVE);
			cmd_q.restore_ctx <= (state_q == mic_pkg::ST_IDLE) && !take_trap && !take_irq &&
				core_evt_i.instr_end && core_evt_i.interrupt_return_instr;
			if (take_trap)
			begin
				cmd_q.vector <= `MIC_VEC_TRAP;
			end
			else if (take_irq)
			begin
				cmd_q.vector <= `MIC_VEC_SRC0 - {11'h000, win_src, 1'b0};
			end
		end
	end

	// which source was last accepted
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			last_src_q  <= 4'h0;
			last_trap_q <= 1'b0;
		end
		else if (take_trap || take_irq)
		begin
			last_src_q  <= take_trap ? 4'h0 : win_src;
			last_trap_q <= take_trap;
		end
	end

	// global mask bit
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mask_q <= 1'b1;
		end
		else if (state_q == mic_pkg::ST_FETCH)
		begin
			mask_q <= 1'b1;
		end
		else if (state_q == mic_pkg::ST_RESTORE)
		begin
			mask_q <= 1'b0;
		end
		else if (state_q == mic_pkg::ST_IDLE && !take_trap && !take_irq)
		begin
			// instructions that set or clear the mask, and low-power entry which clears it
			if (core_evt_i.set_mask)
			begin
				mask_q <= 1'b1;
			end
			else if (core_evt_i.clr_mask || core_evt_i.enter_lp)
			begin
				mask_q <= 1'b0;
			end
		end
	end

	// halt wake set: external lines and spi, line 2 dropped on port b line 4; awu only in awu-from-halt
	always_comb
	begin
		halt_wake_set = 14'h0000;
		halt_wake_set[4:1] = 4'hf;
		halt_wake_set[`MIC_SRC_SPI] = 1'b1;
		if (pinsel_q[5:4] == `MIC_LINE2_NOHALT)
		begin
			halt_wake_set[3] = 1'b0;
		end
		ahalt_wake_set = 14'h0000;
		ahalt_wake_set[`MIC_SRC_AT_OVF] = 1'b1;
		ahalt_wake_set[`MIC_SRC_TB_ONE] = 1'b1;
	end

	// wake decision per power mode
	always_comb
	begin
		case (lp_mode_i)
			mic_pkg::LP_WAIT:        wake_d = |src_req;
			mic_pkg::LP_HALT:        wake_d = |(src_req & halt_wake_set);
			mic_pkg::LP_AWU_HALT:    wake_d = |(src_req & halt_wake_set) |
				src_req[`MIC_SRC_AWU];
			mic_pkg::LP_ACTIVE_HALT: wake_d = |(src_req & ahalt_wake_set);
			default:                 wake_d = 1'b0;
		endcase
	end
	// registered wake level
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wake_q <= 1'b0;
		end
		else
		begin
			wake_q <= wake_d;
		end
	end

	// sensitivity register, guarded by the mask bit
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sens_q <= `MIC_SENS_RESET;
		end
		else if (sens_wr_ok)
		begin
			sens_q <= reg_wdata_i;
		end
	end
	// pin select register
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pinsel_q <= `MIC_PINSEL_RESET;
		end
		else if (reg_wr_i && reg_addr_i == `MIC_ADDR_PINSEL)
		begin
			pinsel_q <= reg_wdata_i;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rdata_d = 8'h00;
		case (reg_addr_i)
			`MIC_ADDR_SENS:    rdata_d = sens_q;
			`MIC_ADDR_PINSEL:  rdata_d = pinsel_q;
			`MIC_ADDR_STATUS:  rdata_d = {3'h0, mask_q, ext_pend_q};
			`MIC_ADDR_LASTSRC: rdata_d = {last_trap_q, 3'h0, last_src_q};
			default:           rdata_d = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= reg_rd_i ? rdata_d : 8'h00;
		end
	end
	// outputs
	assign reg_rdata_o   = rdata_q;
	assign core_cmd_o    = cmd_q;
	assign mask_o        = mask_q;
	assign wake_o        = wake_q;
	assign irq_pending_o = any_req;

endmodule

// *** mic_intc_asserts.sv ***
// concurrent checks on the interrupt controller ports
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps

module mic_intc_checker
(
	input wire logic                   clk_i,
	input wire logic                   reset_i,
	input wire logic [7:0]             reg_addr_i,
	input wire logic [7:0]             reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire logic [7:0]             reg_rdata_o,
	input wire logic [7:0]             port_a_i,
	input wire logic [6:0]             port_b_i,
	input wire logic [3:0]             nand_block_n_i,
	input wire logic [13:0]            periph_flag_i,
	input wire logic [13:0]            periph_en_i,
	input wire mic_pkg::mic_core_evt_t core_evt_i,
	input wire mic_pkg::mic_lp_t       lp_mode_i,
	input wire mic_pkg::mic_core_cmd_t core_cmd_o,
	input wire logic                   mask_o,
	input wire logic                   wake_o,
	input wire logic                   irq_pending_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// vector fetch, then mask raised
	sequence s_fetch;
		core_cmd_o.load_vec ##1 mask_o;
	endsequence
	// entry and return sequencing
	a_reset_masked: assert property ($fell(reset_i) |-> mask_o)
		else $error("mask not set after reset");
	a_save_fetch: assert property (core_cmd_o.save_ctx |=> s_fetch)
		else $error("save not followed by fetch and mask");
	a_restore_unmask: assert property (core_cmd_o.restore_ctx |=> !mask_o)
		else $error("mask not cleared on return");
	// vectors
	a_trap_vector: assert property (core_cmd_o.save_ctx && $past(core_evt_i.trap)
		|-> core_cmd_o.vector == 16'hfffc)
		else $error("trap vector wrong");
	a_vector_range: assert property (core_cmd_o.save_ctx && !$past(core_evt_i.trap)
		|-> !core_cmd_o.vector[0] && core_cmd_o.vector >= 16'hffe2
		&& core_cmd_o.vector <= 16'hfffa && core_cmd_o.vector != 16'hffee)
		else $error("source vector out of range");
	// masking
	a_masked_hold: assert property (core_cmd_o.save_ctx && !$past(core_evt_i.trap)
		|-> !$past(mask_o))
		else $error("irq taken while masked");
	a_pend_unmasked: assert property (irq_pending_o |-> !mask_o)
		else $error("pending shown while masked");
	// wake sources
	a_wait_wake: assert property (lp_mode_i == mic_pkg::LP_WAIT
		&& |(periph_flag_i & periph_en_i & 14'h1fa1) |=> wake_o)
		else $error("no wake from wait");
	a_ahalt_wake: assert property (lp_mode_i == mic_pkg::LP_ACTIVE_HALT
		&& periph_flag_i[9] && periph_en_i[9] |=> wake_o)
		else $error("no wake from active halt");
endmodule

bind mic_intc mic_intc_checker u_mic_intc_checker (
	.clk_i          (clk_i),
	.reset_i        (reset_i),
	.reg_addr_i     (reg_addr_i),
	.reg_wdata_i    (reg_wdata_i),
	.reg_wr_i       (reg_wr_i),
	.reg_rd_i       (reg_rd_i),
	.reg_rdata_o    (reg_rdata_o),
	.port_a_i       (port_a_i),
	.port_b_i       (port_b_i),
	.nand_block_n_i (nand_block_n_i),
	.periph_flag_i  (periph_flag_i),
	.periph_en_i    (periph_en_i),
	.core_evt_i     (core_evt_i),
	.lp_mode_i      (lp_mode_i),
	.core_cmd_o     (core_cmd_o),
	.mask_o         (mask_o),
	.wake_o         (wake_o),
	.irq_pending_o  (irq_pending_o)
);

// *** mic_intc_test.sv ***
// self-checking bench for the interrupt controller with a peripheral latch model
// assumes mic_cfg.svh offsets and the designer's sequencing latencies
`timescale 1ns/1ps
`include "mic_cfg.svh"

module mic_intc_test;
	logic                   clk_i = 1'b0;
	logic                   reset_i = 1'b1;
	logic [7:0]             reg_addr_i = 8'h00;
	logic [7:0]             reg_wdata_i = 8'h00;
	logic                   reg_wr_i = 1'b0;
	logic                   reg_rd_i = 1'b0;
	logic                   rd_p = 1'b0;
	logic [7:0]             port_a_i = 8'hff;
	logic [6:0]             port_b_i = 7'h7f;
	logic [3:0]             nand_block_n_i = 4'hf;
	logic [13:0]            set_evt = 14'h0000;
	logic [13:0]            clr_evt = 14'h0000;
	logic [13:0]            periph_flag_i;
	logic [13:0]            periph_en_i = 14'h3f7f;
	mic_pkg::mic_core_evt_t core_evt_i = '0;
	mic_pkg::mic_lp_t       lp_mode_i = mic_pkg::LP_RUN;
	mic_pkg::mic_core_cmd_t core_cmd_o;
	logic [7:0]             reg_rdata_o;
	logic                   mask_o;
	logic                   wake_o;
	logic                   irq_pending_o;
	logic [15:0]            exp_q[$];
	logic [1:0]             sel0;
	int                     bad_count = 0;
	int                     check_count = 0;
	int                     cyc = 0;

	// 250 MHz clock
	always #2 clk_i = ~clk_i;

	mic_intc u_mic_intc (
		.clk_i          (clk_i),
		.reset_i        (reset_i),
		.reg_addr_i     (reg_addr_i),
		.reg_wdata_i    (reg_wdata_i),
		.reg_wr_i       (reg_wr_i),
		.reg_rd_i       (reg_rd_i),
		.reg_rdata_o    (reg_rdata_o),
		.port_a_i       (port_a_i),
		.port_b_i       (port_b_i),
		.nand_block_n_i (nand_block_n_i),
		.periph_flag_i  (periph_flag_i),
		.periph_en_i    (periph_en_i),
		.core_evt_i     (core_evt_i),
		.lp_mode_i      (lp_mode_i),
		.core_cmd_o     (core_cmd_o),
		.mask_o         (mask_o),
		.wake_o         (wake_o),
		.irq_pending_o  (irq_pending_o)
	);
	mic_periph_model u_mic_periph_model (.clk_i(clk_i), .reset_i(reset_i), .set_i(set_evt),
		.clr_i(clr_evt), .flag_o(periph_flag_i));

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// one-cycle core event, then n idle cycles
	task run(input logic [5:0] v, input int n);
		@(posedge clk_i);
		core_evt_i <= v;
		@(posedge clk_i);
		core_evt_i <= '0;
		repeat (n) @(posedge clk_i);
	endtask

	task pulse_flags(input logic [13:0] s, input logic [13:0] c);
		@(posedge clk_i);
		set_evt <= s;
		clr_evt <= c;
		@(posedge clk_i);
		set_evt <= 14'h0000;
		clr_evt <= 14'h0000;
	endtask

	// read data and vectors compared against the oldest note
	always @(posedge clk_i) rd_p <= reg_rd_i;
	always @(negedge clk_i)
	begin
		if (!reset_i && (rd_p || core_cmd_o.save_ctx))
		begin
			if (exp_q.size() == 0)
				chk("spare result", 16'h0001, 16'h0000);
			else
				chk(rd_p ? "rdata" : "vector",
					rd_p ? {8'h00, reg_rdata_o} : core_cmd_o.vector, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			bad_count++;
			end_sim;
		end
	end

	initial
	begin
		void'($urandom(32'h230c_4c83));
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		@(negedge clk_i);
		chk("mask", {15'h0000, mask_o}, 16'h0001);
		rd(`MIC_ADDR_SENS, 8'h00);
		rd(`MIC_ADDR_PINSEL, 8'h0c);
		sel0 = 2'($urandom_range(3));
		wr(`MIC_ADDR_PINSEL, 8'h0c | {6'h00, sel0});
		wr(`MIC_ADDR_SENS, 8'he4);
		rd(`MIC_ADDR_SENS, 8'he4);
		run(6'h02, 2);
		wr(`MIC_ADDR_SENS, 8'h00);
		rd(`MIC_ADDR_SENS, 8'he4);
		// low level on the chosen line 0 pin, port a line 7 parked low, nand input blocking first
		@(posedge clk_i);
		port_a_i <= 8'hff & ~(8'h01 << sel0) & 8'h7f;
		nand_block_n_i <= 4'he;
		@(negedge clk_i);
		chk("pending", {15'h0000, irq_pending_o}, 16'h0000);
		@(posedge clk_i);
		nand_block_n_i <= 4'hf;
		@(negedge clk_i);
		chk("pending", {15'h0000, irq_pending_o}, 16'h0001);
		exp_q.push_back(16'hfff8);
		run(6'h20, 2);
		port_a_i <= 8'h7f;
		exp_q.push_back(16'hfffc);
		run(6'h30, 2);
		run(6'h28, 2);
		// rising edge on line 1 plus peripheral flags 5, 7 (disabled) and 12
		port_a_i <= 8'hff;
		pulse_flags(14'h10a0, 14'h0000);
		exp_q.push_back(16'hfff6);
		run(6'h20, 2);
		run(6'h28, 2);
		exp_q.push_back(16'hfff0);
		run(6'h20, 2);
		pulse_flags(14'h0000, 14'h0020);
		run(6'h28, 2);
		exp_q.push_back(16'hffe2);
		run(6'h20, 2);
		// wake filtering per power mode
		lp_mode_i <= mic_pkg::LP_ACTIVE_HALT;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("wake", {15'h0000, wake_o}, 16'h0000);
		pulse_flags(14'h0200, 14'h0000);
		@(posedge clk_i);
		@(negedge clk_i);
		chk("wake", {15'h0000, wake_o}, 16'h0001);
		pulse_flags(14'h0000, 14'h0200);
		lp_mode_i <= mic_pkg::LP_WAIT;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("wake", {15'h0000, wake_o}, 16'h0001);
		// halt: the spi flag wakes, flag 5 alone does not
		@(posedge clk_i);
		lp_mode_i <= mic_pkg::LP_HALT;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("wake", {15'h0000, wake_o}, 16'h0001);
		pulse_flags(14'h0020, 14'h1000);
		@(posedge clk_i);
		@(negedge clk_i);
		chk("wake", {15'h0000, wake_o}, 16'h0000);
		@(posedge clk_i);
		lp_mode_i <= mic_pkg::LP_RUN;
		// falling edge on line 2 latched, then dropped by a sensitivity change
		port_b_i <= 7'h77;
		repeat (2) @(posedge clk_i);
		rd(`MIC_ADDR_STATUS, 8'h14);
		wr(`MIC_ADDR_SENS, 8'hf4);
		rd(`MIC_ADDR_STATUS, 8'h10);
		// second reset in mid-run, after low-power entry has cleared the mask
		run(6'h01, 1);
		@(negedge clk_i);
		chk("mask", {15'h0000, mask_o}, 16'h0000);
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		@(negedge clk_i);
		chk("mask", {15'h0000, mask_o}, 16'h0001);
		chk("leftover", 16'(exp_q.size()), 16'h0000);
		end_sim;
	end
endmodule

// *** mic_periph_model.sv ***
// peripheral flag latches that stand on the far side of the interrupt controller
// assumes set and clear pulses come from the bench, synchronous to clk_i
`timescale 1ns/1ps

module mic_periph_model
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [13:0] set_i,
	input  wire logic [13:0] clr_i,
	output logic      [13:0] flag_o
);
	// flag stays pending until cleared; a clear drops the pending request
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			flag_o <= 14'h0000;
		else
			flag_o <= (flag_o & ~clr_i) | set_i;
	end
endmodule

// *** mic_pkg.sv ***
// types shared by the interrupt controller and its surroundings
// assumes mic_cfg.svh for all numeric constants
package mic_pkg;
	// trigger type of one external line
	typedef enum logic [1:0] {
		SENS_FALL_LOW = 2'h0,
		SENS_RISE     = 2'h1,
		SENS_FALL     = 2'h2,
		SENS_BOTH     = 2'h3
	} mic_sens_t;
	// power mode reported by the core
	typedef enum logic [2:0] {
		LP_RUN, LP_WAIT, LP_HALT, LP_ACTIVE_HALT, LP_AWU_HALT
	} mic_lp_t;
	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_FETCH, ST_RESTORE} mic_state_t;
	// events from the core, one-cycle pulses
	typedef struct packed {
		logic instr_end;
		logic trap;
		logic interrupt_return_instr;
		logic set_mask;
		logic clr_mask;
		logic enter_lp;
	} mic_core_evt_t;
	// commands to the core
	typedef struct packed {
		logic        save_ctx;
		logic        load_vec;
		logic        restore_ctx;
		logic [15:0] vector;
	} mic_core_cmd_t;
endpackage
